// ### design/pmbus_limit_status_command_bank.sv
// Command register bank of a digital power controller.
`timescale 1ns/1ps
module pmbus_limit_status_command_bank (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic cmd_valid_i,
   input wire logic cmd_write_i,
   input wire logic [7:0] cmd_code_i,
   input wire logic [15:0] cmd_wdata_i,
   input wire logic [7:0] str_index_i,
   input wire logic [15:0] setpoint_strap_pin_i,
   input wire logic [15:0] status_word_i,
   input wire logic [7:0] output_voltage_status_i,
   input wire logic [7:0] output_current_status_i,
   input wire logic [7:0] status_input_i,
   input wire logic [7:0] status_thermal_i,
   input wire logic [7:0] comm_memory_logic_status_i,
   input wire logic [7:0] status_vendor_i,
   input wire logic [15:0] vin_meas_i,
   input wire logic [15:0] iin_meas_i,
   input wire logic [15:0] vout_meas_i,
   input wire logic [15:0] iout_meas_i,
   input wire logic [15:0] temp_int_meas_i,
   input wire logic [15:0] external_sense_pin_i,
   input wire logic [15:0] duty_meas_i,
   input wire logic [15:0] freq_meas_i,
   input wire logic [15:0] pout_calc_i,
   input wire logic [15:0] pin_calc_i,
   output logic rsp_valid_o,
   output logic rsp_ack_o,
   output logic [15:0] rsp_rdata_o,
   output logic [15:0] vout_low_warn_o,
   output logic [15:0] vout_low_fault_o,
   output logic [15:0] turn_on_wait_o,
   output logic [15:0] turn_on_ramp_o,
   output logic [15:0] turn_off_wait_o,
   output logic [15:0] turn_off_ramp_o
);
   import pmbus_bank_pkg::*;

   logic strap_s1, strap_s2;
   logic [15:0] strap_a, strap_b;
   logic strap_loaded;
   logic vout_low_warn_set, vout_low_fault_set;
   logic good_output_set;
   logic [15:0] vout_low_warn_reg, vout_low_fault_reg;
   logic [15:0] good_output;
   logic [7:0] vout_low_action, hot_action, cold_action;
   logic [7:0] vin_high_action, vin_low_action;
   logic [15:0] iout_peak_fault, iout_peak_warn, iout_valley_fault;
   logic [15:0] hot_fault, hot_warn, cold_warn, cold_fault;
   logic [15:0] vin_high_fault, vin_high_warn, vin_low_warn, vin_low_fault;
   logic [15:0] turn_on_wait, turn_on_ramp, turn_off_wait, turn_off_ramp;
   logic [7:0] strings [string_count][string_len];
   logic [7:0] string_length [string_count];
   logic wr, rd;
   logic [15:0] next_rdata;
   logic next_ack;
   logic [2:0] str_sel;

   // Scale an unsigned setpoint by a fraction in hundredths.
   function automatic logic [15:0] scale(input logic [15:0] v,
                                         input logic [7:0] pct);
      logic [23:0] p;
      p = 24'(v) * 24'(pct);
      return 16'(p / 24'd100);
   endfunction

   // True for the six host string commands.
   function automatic logic is_string_code(input logic [7:0] code);
      return code >= cmd_string_first && code <= cmd_string_last;
   endfunction

   assign wr = cmd_valid_i && cmd_write_i;
   assign rd = cmd_valid_i && !cmd_write_i;
   assign str_sel = 3'(cmd_code_i - cmd_string_first);

   // The strap is a pin and is synchronised before it is held.
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         strap_a <= 16'h0000;
         strap_b <= 16'h0000;
         strap_s1 <= 1'b0;
         strap_s2 <= 1'b0;
      end else begin
         strap_a <= setpoint_strap_pin_i;
         strap_b <= strap_a;
         strap_s1 <= 1'b1;
         strap_s2 <= strap_s1;
      end
   end

   // The strap is caught once after release so a moving pin cannot shift
   // limits the host relies on.
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         strap_loaded <= 1'b0;
         vout_low_warn_reg <= 16'h0000;
         vout_low_fault_reg <= 16'h0000;
         good_output <= 16'h0000;
         good_output_set <= 1'b0;
         vout_low_warn_set <= 1'b0;
         vout_low_fault_set <= 1'b0;
      end else begin
         if (strap_s2 && !strap_loaded) begin
            strap_loaded <= 1'b1;
            if (!vout_low_warn_set)
               vout_low_warn_reg <= scale(strap_b, 8'd90);
            if (!vout_low_fault_set)
               vout_low_fault_reg <= scale(strap_b, 8'd85);
            if (!good_output_set)
               good_output <= scale(strap_b, 8'd90);
         end
         if (wr && cmd_code_i == cmd_vout_low_warn) begin
            vout_low_warn_reg <= cmd_wdata_i;
            vout_low_warn_set <= 1'b1;
         end
         if (wr && cmd_code_i == cmd_vout_low_fault) begin
            vout_low_fault_reg <= cmd_wdata_i;
            vout_low_fault_set <= 1'b1;
         end
         if (wr && cmd_code_i == cmd_good_output) begin
            good_output <= cmd_wdata_i;
            good_output_set <= 1'b1;
         end
      end
   end

   // Fault actions take any byte; the action logic decides what a
   // reserved pattern means.
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         vout_low_action <= rst_fault_action;
         hot_action <= rst_fault_action;
         cold_action <= rst_fault_action;
         vin_high_action <= rst_fault_action;
         vin_low_action <= rst_fault_action;
      end else if (wr) begin
         unique case (cmd_code_i)
            cmd_vout_low_action: vout_low_action <= cmd_wdata_i[7:0];
            cmd_hot_action: hot_action <= cmd_wdata_i[7:0];
            cmd_cold_action: cold_action <= cmd_wdata_i[7:0];
            cmd_vin_high_action: vin_high_action <= cmd_wdata_i[7:0];
            cmd_vin_low_action: vin_low_action <= cmd_wdata_i[7:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         iout_peak_fault <= rst_iout_peak_fault;
         iout_peak_warn <= rst_iout_peak_warn;
         iout_valley_fault <= rst_iout_valley_fault;
      end else if (wr) begin
         unique case (cmd_code_i)
            cmd_iout_peak_fault: iout_peak_fault <= cmd_wdata_i;
            cmd_iout_peak_warn: iout_peak_warn <= cmd_wdata_i;
            cmd_iout_valley_fault: iout_valley_fault <= cmd_wdata_i;
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         hot_fault <= rst_hot_fault;
         hot_warn <= rst_hot_warn;
         cold_warn <= rst_cold_warn;
         cold_fault <= rst_cold_fault;
      end else if (wr) begin
         unique case (cmd_code_i)
            cmd_hot_fault: hot_fault <= cmd_wdata_i;
            cmd_hot_warn: hot_warn <= cmd_wdata_i;
            cmd_cold_warn: cold_warn <= cmd_wdata_i;
            cmd_cold_fault: cold_fault <= cmd_wdata_i;
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         vin_high_fault <= rst_vin_high_fault;
         vin_high_warn <= rst_vin_high_warn;
         vin_low_warn <= rst_vin_low_warn;
         vin_low_fault <= rst_vin_low_fault;
      end else if (wr) begin
         unique case (cmd_code_i)
            cmd_vin_high_fault: vin_high_fault <= cmd_wdata_i;
            cmd_vin_high_warn: vin_high_warn <= cmd_wdata_i;
            cmd_vin_low_warn: vin_low_warn <= cmd_wdata_i;
            cmd_vin_low_fault: vin_low_fault <= cmd_wdata_i;
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         turn_on_wait <= rst_turn_on_wait;
         turn_on_ramp <= rst_turn_on_ramp;
         turn_off_wait <= rst_turn_off_wait;
         turn_off_ramp <= rst_turn_off_ramp;
      end else if (wr) begin
         unique case (cmd_code_i)
            cmd_turn_on_wait: turn_on_wait <= cmd_wdata_i;
            cmd_turn_on_ramp: turn_on_ramp <= cmd_wdata_i;
            cmd_turn_off_wait: turn_off_wait <= cmd_wdata_i;
            cmd_turn_off_ramp: turn_off_ramp <= cmd_wdata_i;
            default: ;
         endcase
      end
   end

   // Strings are written one byte at a time; index zero starts a new string,
   // so a shorter rewrite never leaves old tail bytes readable.
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         for (int i = 0; i < string_count; i++) begin
            string_length[i] <= 8'h00;
            for (int j = 0; j < string_len; j++)
               strings[i][j] <= 8'h00;
         end
      end else if (wr && is_string_code(cmd_code_i) &&
                   str_index_i < 8'(string_len)) begin
         strings[str_sel][str_index_i[3:0]] <= cmd_wdata_i[7:0];
         if (str_index_i == 8'h00)
            string_length[str_sel] <= 8'h01;
         else if (str_index_i >= string_length[str_sel])
            string_length[str_sel] <= str_index_i + 8'h01;
      end
   end

   always_comb begin
      next_rdata = 16'h0000;
      next_ack = 1'b1;
      unique case (cmd_code_i)
         cmd_vout_low_warn: next_rdata = vout_low_warn_reg;
         cmd_vout_low_fault: next_rdata = vout_low_fault_reg;
         cmd_vout_low_action: next_rdata = {8'h00, vout_low_action};
         cmd_iout_peak_fault: next_rdata = iout_peak_fault;
         cmd_iout_peak_warn: next_rdata = iout_peak_warn;
         cmd_iout_valley_fault: next_rdata = iout_valley_fault;
         cmd_hot_fault: next_rdata = hot_fault;
         cmd_hot_action: next_rdata = {8'h00, hot_action};
         cmd_hot_warn: next_rdata = hot_warn;
         cmd_cold_warn: next_rdata = cold_warn;
         cmd_cold_fault: next_rdata = cold_fault;
         cmd_cold_action: next_rdata = {8'h00, cold_action};
         cmd_vin_high_fault: next_rdata = vin_high_fault;
         cmd_vin_high_action: next_rdata = {8'h00, vin_high_action};
         cmd_vin_high_warn: next_rdata = vin_high_warn;
         cmd_vin_low_warn: next_rdata = vin_low_warn;
         cmd_vin_low_fault: next_rdata = vin_low_fault;
         cmd_vin_low_action: next_rdata = {8'h00, vin_low_action};
         cmd_good_output: next_rdata = good_output;
         cmd_turn_on_wait: next_rdata = turn_on_wait;
         cmd_turn_on_ramp: next_rdata = turn_on_ramp;
         cmd_turn_off_wait: next_rdata = turn_off_wait;
         cmd_turn_off_ramp: next_rdata = turn_off_ramp;
         cmd_status_low_byte: next_rdata = {8'h00, status_word_i[7:0]};
         cmd_status_word: next_rdata = status_word_i;
         cmd_output_voltage_status: next_rdata = {8'h00, output_voltage_status_i};
         cmd_output_current_status: next_rdata = {8'h00, output_current_status_i};
         cmd_status_input: next_rdata = {8'h00, status_input_i};
         cmd_status_thermal: next_rdata = {8'h00, status_thermal_i};
         cmd_comm_memory_logic_status: next_rdata = {8'h00, comm_memory_logic_status_i};
         cmd_status_vendor: next_rdata = {8'h00, status_vendor_i};
         cmd_input_voltage_reading: next_rdata = vin_meas_i;
         cmd_input_current_reading: next_rdata = iin_meas_i;
         cmd_output_voltage_reading: next_rdata = vout_meas_i;
         cmd_output_current_reading: next_rdata = iout_meas_i;
         cmd_read_temp_int: next_rdata = temp_int_meas_i;
         cmd_read_temp_ext: next_rdata = external_sense_pin_i;
         cmd_read_duty: next_rdata = duty_meas_i;
         cmd_read_freq: next_rdata = freq_meas_i;
         cmd_output_power_reading: next_rdata = pout_calc_i;
         cmd_read_pin: next_rdata = pin_calc_i;
         cmd_protocol_revision:
            next_rdata = {8'h00, protocol_revision_value};
         default: begin
            if (is_string_code(cmd_code_i)) begin
               if (str_index_i == 8'hff)
                  next_rdata = {8'h00, string_length[str_sel]};
               else if (str_index_i < string_length[str_sel])
                  next_rdata = {8'h00, strings[str_sel][str_index_i[3:0]]};
            end else begin
               next_ack = 1'b0;
            end
         end
      endcase
      // Writes to read-only codes are refused, not silently dropped.
      if (cmd_write_i && cmd_code_i >= cmd_status_low_byte &&
          cmd_code_i <= cmd_protocol_revision)
         next_ack = 1'b0;
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rsp_valid_o <= 1'b0;
         rsp_ack_o <= 1'b0;
         rsp_rdata_o <= 16'h0000;
      end else begin
         rsp_valid_o <= cmd_valid_i;
         rsp_ack_o <= cmd_valid_i && next_ack;
         rsp_rdata_o <= rd ? next_rdata : 16'h0000;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         vout_low_warn_o <= 16'h0000;
         vout_low_fault_o <= 16'h0000;
         turn_on_wait_o <= rst_turn_on_wait;
         turn_on_ramp_o <= rst_turn_on_ramp;
         turn_off_wait_o <= rst_turn_off_wait;
         turn_off_ramp_o <= rst_turn_off_ramp;
      end else begin
         vout_low_warn_o <= vout_low_warn_reg;
         vout_low_fault_o <= vout_low_fault_reg;
         turn_on_wait_o <= turn_on_wait;
         turn_on_ramp_o <= turn_on_ramp;
         turn_off_wait_o <= turn_off_wait;
         turn_off_ramp_o <= turn_off_ramp;
      end
   end
endmodule

// ### design/pmbus_bank_pkg.sv
// Constants shared by the command register bank.
package pmbus_bank_pkg;
   localparam logic [7:0] cmd_vout_low_warn = 8'h43;
   localparam logic [7:0] cmd_vout_low_fault = 8'h44;
   localparam logic [7:0] cmd_vout_low_action = 8'h45;
   localparam logic [7:0] cmd_iout_peak_fault = 8'h46;
   localparam logic [7:0] cmd_iout_peak_warn = 8'h4a;
   localparam logic [7:0] cmd_iout_valley_fault = 8'h4b;
   localparam logic [7:0] cmd_hot_fault = 8'h4f;
   localparam logic [7:0] cmd_hot_action = 8'h50;
   localparam logic [7:0] cmd_hot_warn = 8'h51;
   localparam logic [7:0] cmd_cold_warn = 8'h52;
   localparam logic [7:0] cmd_cold_fault = 8'h53;
   localparam logic [7:0] cmd_cold_action = 8'h54;
   localparam logic [7:0] cmd_vin_high_fault = 8'h55;
   localparam logic [7:0] cmd_vin_high_action = 8'h56;
   localparam logic [7:0] cmd_vin_high_warn = 8'h57;
   localparam logic [7:0] cmd_vin_low_warn = 8'h58;
   localparam logic [7:0] cmd_vin_low_fault = 8'h59;
   localparam logic [7:0] cmd_vin_low_action = 8'h5a;
   localparam logic [7:0] cmd_good_output = 8'h5e;
   localparam logic [7:0] cmd_turn_on_wait = 8'h60;
   localparam logic [7:0] cmd_turn_on_ramp = 8'h61;
   localparam logic [7:0] cmd_turn_off_wait = 8'h64;
   localparam logic [7:0] cmd_turn_off_ramp = 8'h65;
   localparam logic [7:0] cmd_status_low_byte = 8'h78;
   localparam logic [7:0] cmd_status_word = 8'h79;
   localparam logic [7:0] cmd_output_voltage_status = 8'h7a;
   localparam logic [7:0] cmd_output_current_status = 8'h7b;
   localparam logic [7:0] cmd_status_input = 8'h7c;
   localparam logic [7:0] cmd_status_thermal = 8'h7d;
   localparam logic [7:0] cmd_comm_memory_logic_status = 8'h7e;
   localparam logic [7:0] cmd_status_vendor = 8'h80;
   localparam logic [7:0] cmd_input_voltage_reading = 8'h88;
   localparam logic [7:0] cmd_input_current_reading = 8'h89;
   localparam logic [7:0] cmd_output_voltage_reading = 8'h8b;
   localparam logic [7:0] cmd_output_current_reading = 8'h8c;
   localparam logic [7:0] cmd_read_temp_int = 8'h8d;
   localparam logic [7:0] cmd_read_temp_ext = 8'h8e;
   localparam logic [7:0] cmd_read_duty = 8'h94;
   localparam logic [7:0] cmd_read_freq = 8'h95;
   localparam logic [7:0] cmd_output_power_reading = 8'h96;
   localparam logic [7:0] cmd_read_pin = 8'h97;
   localparam logic [7:0] cmd_protocol_revision = 8'h98;
   localparam logic [7:0] cmd_string_first = 8'h99;
   localparam logic [7:0] cmd_string_last = 8'h9e;
   localparam logic [7:0] rst_fault_action = 8'h80;
   localparam logic [15:0] rst_iout_peak_fault = 16'he2d0;
   localparam logic [15:0] rst_iout_peak_warn = 16'hdbc0;
   localparam logic [15:0] rst_iout_valley_fault = 16'he530;
   localparam logic [15:0] rst_hot_fault = 16'hebe8;
   localparam logic [15:0] rst_hot_warn = 16'heb70;
   localparam logic [15:0] rst_cold_warn = 16'hdc40;
   localparam logic [15:0] rst_cold_fault = 16'he530;
   localparam logic [15:0] rst_vin_high_fault = 16'hda00;
   localparam logic [15:0] rst_vin_high_warn = 16'hd3e0;
   localparam logic [15:0] rst_vin_low_warn = 16'hcb80;
   localparam logic [15:0] rst_vin_low_fault = 16'hcb40;
   localparam logic [15:0] rst_turn_on_wait = 16'h0000;
   localparam logic [15:0] rst_turn_on_ramp = 16'hca80;
   localparam logic [15:0] rst_turn_off_wait = 16'h0000;
   localparam logic [15:0] rst_turn_off_ramp = 16'hca80;
   localparam logic [7:0] protocol_revision_value = 8'h33;
   localparam int string_len = 16;
   localparam int string_count = 6;
endpackage

// ### sim/pmbus_bank_props.sv
// Port checks for the command register bank.
`timescale 1ns/1ps
module pmbus_bank_props (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic cmd_valid_i,
   input wire logic cmd_write_i,
   input wire logic [7:0] cmd_code_i,
   input wire logic [15:0] cmd_wdata_i,
   input wire logic [15:0] status_word_i,
   input wire logic [15:0] vout_meas_i,
   input wire logic rsp_valid_o,
   input wire logic rsp_ack_o,
   input wire logic [15:0] rsp_rdata_o,
   input wire logic [15:0] turn_on_wait_o,
   input wire logic [15:0] turn_off_ramp_o
);
   logic off_wr;
   assign off_wr = cmd_valid_i & cmd_write_i & (cmd_code_i == 8'h65);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   sequence rd_of(logic [7:0] c);
      cmd_valid_i && !cmd_write_i && cmd_code_i == c;
   endsequence
   sequence wr_of(logic [7:0] c);
      cmd_valid_i && cmd_write_i && cmd_code_i == c;
   endsequence
   rsp_follows_a: assert property (cmd_valid_i |=> rsp_valid_o)
      else $error("no response one cycle after a command");
   rsp_alone_a: assert property (!cmd_valid_i |=> !rsp_valid_o)
      else $error("response without a command");
   unknown_code_a: assert property (
      cmd_valid_i && (cmd_code_i < 8'h43 || cmd_code_i > 8'h9e) |=> !rsp_ack_o)
      else $error("unknown code acknowledged");
   ro_write_refused_a: assert property (
      cmd_valid_i && cmd_write_i && cmd_code_i inside {[8'h78:8'h98]}
      |=> rsp_valid_o && !rsp_ack_o)
      else $error("write to a read-only command acknowledged");
   revision_read_a: assert property (
      rd_of(8'h98) |=> rsp_ack_o && rsp_rdata_o == 16'h0033)
      else $error("protocol revision read wrong");
   status_word_a: assert property (
      rd_of(8'h79) |=> rsp_ack_o && rsp_rdata_o == $past(status_word_i))
      else $error("status word read wrong");
   status_byte_a: assert property (
      rd_of(8'h78) |=> rsp_rdata_o == ($past(status_word_i) & 16'h00ff))
      else $error("status low byte read wrong");
   vout_readout_a: assert property (
      rd_of(8'h8b) |=> rsp_rdata_o == $past(vout_meas_i))
      else $error("output voltage readout wrong");
   on_wait_write_a: assert property (
      wr_of(8'h60) |=> rsp_ack_o ##1 turn_on_wait_o == $past(cmd_wdata_i, 2))
      else $error("turn-on wait output does not follow write");
   off_ramp_hold_a: assert property (
      !$past(off_wr, 2) |-> $stable(turn_off_ramp_o))
      else $error("turn-off ramp output changed without a write");
endmodule
bind pmbus_limit_status_command_bank pmbus_bank_props props (
   .clk_i, .rst_b_i, .cmd_valid_i, .cmd_write_i, .cmd_code_i, .cmd_wdata_i,
   .status_word_i, .vout_meas_i, .rsp_valid_o, .rsp_ack_o, .rsp_rdata_o,
   .turn_on_wait_o, .turn_off_ramp_o);

// ### sim/pmbus_host_model.sv
// Host side model that issues decoded command transactions.
`timescale 1ns/1ps
module pmbus_host_model (
   input wire logic clk_i,
   output logic cmd_valid_o,
   output logic cmd_write_o,
   output logic [7:0] cmd_code_o,
   output logic [15:0] cmd_wdata_o,
   output logic [7:0] str_index_o,
   input wire logic rsp_valid_i,
   input wire logic rsp_ack_i,
   input wire logic [15:0] rsp_rdata_i
);
   initial begin
      cmd_valid_o = 1'b0;
      cmd_write_o = 1'b0;
      cmd_code_o = 8'h00;
      cmd_wdata_o = 16'h0000;
      str_index_o = 8'h00;
   end
   // Called at an edge; released fields are inverted so a stale value
   // cannot pass for a held one.
   task automatic xfer(input logic w, input logic [7:0] c,
         input logic [7:0] idx, input logic [15:0] d,
         output logic vld, output logic ack, output logic [15:0] rd);
      cmd_valid_o <= 1'b1;
      cmd_write_o <= w;
      cmd_code_o <= c;
      cmd_wdata_o <= d;
      str_index_o <= idx;
      @(posedge clk_i);
      cmd_valid_o <= 1'b0;
      cmd_write_o <= ~w;
      cmd_code_o <= ~c;
      cmd_wdata_o <= ~d;
      str_index_o <= ~idx;
      @(posedge clk_i);
      vld = rsp_valid_i;
      ack = rsp_ack_i;
      rd = rsp_rdata_i;
   endtask
endmodule

// ### sim/testbench.sv
// Self-checking bench for the command register bank.
`timescale 1ns/1ps
module testbench;
   logic clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic cv, cw, vld, ack;
   logic [7:0] cc, si, c;
   logic [15:0] cd, rd, m, e, lw, lf, onw, onr, ofw, ofr, rdat;
   logic rv, ra;
   logic [15:0] strap = 16'h1000;
   logic [15:0] sw = 16'h0000;
   logic [7:0] sb [6] = '{default: 8'h00};
   logic [15:0] meas [10] = '{default: 16'h0000};
   int n_errors = 0;
   int cmp_count = 0;
   localparam logic [7:0] rw_code [20] = '{8'h45, 8'h46, 8'h4a, 8'h4b, 8'h4f,
      8'h50, 8'h51, 8'h52, 8'h53, 8'h54, 8'h55, 8'h56, 8'h57, 8'h58, 8'h59,
      8'h5a, 8'h60, 8'h61, 8'h64, 8'h65};
   localparam logic [15:0] rw_rst [20] = '{16'h0080, 16'he2d0, 16'hdbc0,
      16'he530, 16'hebe8, 16'h0080, 16'heb70, 16'hdc40, 16'he530, 16'h0080,
      16'hda00, 16'h0080, 16'hd3e0, 16'hcb80, 16'hcb40, 16'h0080, 16'h0000,
      16'hca80, 16'h0000, 16'hca80};
   localparam logic [7:0] st_code [8] = '{8'h78, 8'h79, 8'h7a, 8'h7b, 8'h7c,
      8'h7d, 8'h7e, 8'h80};
   localparam logic [7:0] ro_code [10] = '{8'h88, 8'h89, 8'h8b, 8'h8c, 8'h8d,
      8'h8e, 8'h94, 8'h95, 8'h96, 8'h97};
   always #5 clk_i = ~clk_i;
   pmbus_host_model host (.clk_i(clk_i), .cmd_valid_o(cv), .cmd_write_o(cw),
      .cmd_code_o(cc), .cmd_wdata_o(cd), .str_index_o(si),
      .rsp_valid_i(rv), .rsp_ack_i(ra), .rsp_rdata_i(rdat));
   pmbus_limit_status_command_bank dut (
      .clk_i(clk_i), .rst_b_i(rst_b_i), .cmd_valid_i(cv), .cmd_write_i(cw),
      .cmd_code_i(cc), .cmd_wdata_i(cd), .str_index_i(si),
      .setpoint_strap_pin_i(strap), .status_word_i(sw),
      .output_voltage_status_i(sb[0]), .output_current_status_i(sb[1]), .status_input_i(sb[2]),
      .status_thermal_i(sb[3]), .comm_memory_logic_status_i(sb[4]), .status_vendor_i(sb[5]),
      .vin_meas_i(meas[0]), .iin_meas_i(meas[1]), .vout_meas_i(meas[2]),
      .iout_meas_i(meas[3]), .temp_int_meas_i(meas[4]),
      .external_sense_pin_i(meas[5]), .duty_meas_i(meas[6]),
      .freq_meas_i(meas[7]), .pout_calc_i(meas[8]), .pin_calc_i(meas[9]),
      .rsp_valid_o(rv), .rsp_ack_o(ra), .rsp_rdata_o(rdat),
      .vout_low_warn_o(lw), .vout_low_fault_o(lf), .turn_on_wait_o(onw),
      .turn_on_ramp_o(onr), .turn_off_wait_o(ofw), .turn_off_ramp_o(ofr));
   task automatic check16(input string what, input logic [15:0] exp,
         input logic [15:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic xf(input logic w, input logic [7:0] code,
         input logic [7:0] idx, input logic [15:0] d);
      host.xfer(w, code, idx, d, vld, ack, rd);
      check16("response valid", 16'h0001, {15'h0000, vld});
   endtask
   task automatic results();
      if (n_errors == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // The whole run needs a few hundred cycles; this leaves ample margin.
   initial begin
      repeat (5000) @(posedge clk_i);
      n_errors++;
      results();
   end
   initial begin
      repeat (2) @(posedge clk_i);
      rst_b_i <= 1'b1;
      repeat (5) @(posedge clk_i);
      check16("on ramp out", 16'hca80, onr);
      check16("off ramp out", 16'hca80, ofr);
      check16("on wait out", 16'h0000, onw);
      check16("off wait out", 16'h0000, ofw);
      e = 16'(strap * 32'd90 / 32'd100);
      check16("low warn out", e, lw);
      check16("low fault out", 16'(strap * 32'd85 / 32'd100), lf);
      xf(1'b0, 8'h43, 8'h00, 16'h0000);
      check16("low warn", e, rd);
      xf(1'b0, 8'h44, 8'h00, 16'h0000);
      check16("low fault", 16'(strap * 32'd85 / 32'd100), rd);
      xf(1'b1, 8'h43, 8'h00, 16'h1234);
      xf(1'b0, 8'h43, 8'h00, 16'h0000);
      check16("low warn written", 16'h1234, rd);
      check16("low warn out written", 16'h1234, lw);
      foreach (rw_code[i]) begin
         xf(1'b0, rw_code[i], 8'h00, 16'h0000);
         check16("reset", rw_rst[i], rd);
      end
      foreach (rw_code[i]) begin
         c = rw_code[i];
         m = (c inside {8'h45, 8'h50, 8'h54, 8'h56, 8'h5a}) ?
            16'h00ff : 16'hffff;
         e = {c, ~c} & m;
         xf(1'b1, c, 8'h00, {c, ~c});
         check16("write ack", 16'h0001, {15'h0000, ack});
         xf(1'b0, c, 8'h00, 16'h0000);
         check16("readback", e, rd);
      end
      check16("on wait out", 16'h609f, onw);
      check16("on ramp out", 16'h619e, onr);
      check16("off wait out", 16'h649b, ofw);
      check16("off ramp out", 16'h659a, ofr);
      for (int p = 0; p < 2; p++) begin
         foreach (st_code[i]) begin
            xf(1'b0, st_code[i], 8'h00, 16'h0000);
            e = (i == 0) ? {8'h00, sw[7:0]} : (i == 1) ? sw : {8'h00, sb[i-2]};
            check16("status", e, rd);
         end
         sw <= 16'h8421;
         foreach (sb[k]) sb[k] <= 8'(8'h11 * (k + 1));
      end
      foreach (meas[i]) meas[i] <= 16'(32'h1000 + i * 32'h0111);
      foreach (ro_code[i]) begin
         xf(1'b0, ro_code[i], 8'h00, 16'h0000);
         check16("readout", meas[i], rd);
      end
      xf(1'b1, 8'h79, 8'h00, 16'hffff);
      check16("status write ack", 16'h0000, {15'h0000, ack});
      xf(1'b1, 8'h98, 8'h00, 16'h0000);
      check16("revision write ack", 16'h0000, {15'h0000, ack});
      xf(1'b0, 8'h98, 8'h00, 16'h0000);
      check16("revision", 16'h0033, rd);
      xf(1'b0, 8'h47, 8'h00, 16'h0000);
      check16("unmapped ack", 16'h0000, {15'h0000, ack});
      xf(1'b0, 8'h9f, 8'h00, 16'h0000);
      check16("out of range ack", 16'h0000, {15'h0000, ack});
      for (int s = 0; s < 6; s++) begin
         c = 8'(8'h99 + s);
         xf(1'b0, c, 8'hff, 16'h0000);
         check16("empty length", 16'h0000, rd);
         xf(1'b1, c, 8'h00, 16'(65 + s));
         xf(1'b1, c, 8'h01, 16'(97 + s));
         xf(1'b0, c, 8'h00, 16'h0000);
         check16("string byte 0", 16'(65 + s), rd);
         xf(1'b0, c, 8'h01, 16'h0000);
         check16("string byte 1", 16'(97 + s), rd);
         xf(1'b0, c, 8'hff, 16'h0000);
         check16("string length", 16'h0002, rd);
      end
      xf(1'b1, 8'h99, 8'h00, 16'h005a);
      xf(1'b0, 8'h99, 8'h01, 16'h0000);
      check16("stale tail", 16'h0000, rd);
      xf(1'b0, 8'h99, 8'hff, 16'h0000);
      check16("short length", 16'h0001, rd);
      results();
   end
endmodule
